// File: adcsp_serial.sv
`timescale 1ns/100ps
`include "adcsp_cfg.svh"

// ----------------------------------------------------------------
// Control byte receiver, rising serial clock
// ----------------------------------------------------------------
module adcsp_rx
    import adcsp_pkg::*;
(
    // Link
    input  wire logic       i_sclk,
    input  wire logic       i_link_rst_b,
    input  wire logic       i_din,
    input  wire logic       i_conv_done,
    // Control byte
    output logic            o_byte_done,
    output logic [7:0]      o_byte,
    output adcsp_rx_phase_t o_phase
);
    typedef struct packed {
        adcsp_rx_phase_t phase;
        logic [6:0]      shift;
        logic [2:0]      cnt;
    } adcsp_rx_st_t;

    adcsp_rx_st_t st_reg;
    adcsp_rx_st_t st_next;

    always_comb begin
        st_next = st_reg;
        case (st_reg.phase)
            rx_hunt: begin
                if (i_din) begin
                    st_next.phase = rx_ctrl;
                    st_next.shift = 7'h01;
                    st_next.cnt   = 3'h1;
                end
            end
            rx_ctrl: begin
                st_next.shift = {st_reg.shift[5:0], i_din};
                st_next.cnt   = st_reg.cnt + 3'h1;
                if (st_reg.cnt == `ADCSP_CTRL_LAST) begin
                    st_next.phase = rx_conv;
                end
            end
            rx_conv: begin
                if (i_conv_done) begin
                    st_next.phase = rx_hunt;
                end
            end
            default: st_next.phase = rx_hunt;
        endcase
    end

    // Select high holds this in reset, so no bit is taken then.
    always_ff @(posedge i_sclk or negedge i_link_rst_b) begin
        if (!i_link_rst_b) begin
            st_reg <= '{phase: rx_hunt, shift: 7'h00, cnt: 3'h0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_byte_done = (st_reg.phase == rx_ctrl) && (st_reg.cnt == `ADCSP_CTRL_LAST);
    assign o_byte      = {st_reg.shift, i_din};
    assign o_phase     = st_reg.phase;

    property p_start_bit;
        @(posedge i_sclk) disable iff (!i_link_rst_b)
        (st_reg.phase == rx_hunt && i_din) |=> (st_reg.phase == rx_ctrl) ##7
            (st_reg.phase == rx_conv);
    endproperty
    a_start_bit: assert property (p_start_bit)
        else $error("Start bit did not open an eight-bit control byte.");

endmodule // adcsp_rx

// ----------------------------------------------------------------
// Word and control handover, rising serial clock, frame-independent
// ----------------------------------------------------------------
module adcsp_xfer #(
    parameter int RES_W = `ADCSP_RES_W
) (
    // Link
    input  wire logic             i_sclk,
    input  wire logic             i_rst_b,
    // Word offered by the system side
    input  wire logic             i_req_tog,
    input  wire logic [RES_W-1:0] i_hold_word,
    output logic                  o_ack_tog,
    // Control byte from the receiver
    input  wire logic             i_byte_done,
    input  wire logic [7:0]       i_byte,
    output logic                  o_ctrl_tog,
    output logic [7:0]            o_ctrl_byte,
    output logic [RES_W-1:0]      o_conv_word
);
    typedef struct packed {
        logic             req_s1;
        logic             req_s2;
        logic             req_seen;
        logic             full;
        logic [RES_W-1:0] shadow;
        logic [RES_W-1:0] conv_word;
        logic             ack_tog;
        logic             ctrl_tog;
        logic [7:0]       ctrl_byte;
    } adcsp_xfer_st_t;

    adcsp_xfer_st_t st_reg;
    adcsp_xfer_st_t st_next;

    always_comb begin
        st_next        = st_reg;
        st_next.req_s1 = i_req_tog;
        st_next.req_s2 = st_reg.req_s1;
        if (i_byte_done) begin
            st_next.ctrl_byte = i_byte;
            st_next.ctrl_tog  = ~st_reg.ctrl_tog;
            st_next.conv_word = st_reg.full ? st_reg.shadow : '0;
            st_next.full      = 1'b0;
        end
        if (!st_reg.full && (st_reg.req_s2 != st_reg.req_seen)) begin
            st_next.shadow   = i_hold_word;
            st_next.full     = 1'b1;
            st_next.req_seen = st_reg.req_s2;
            st_next.ack_tog  = ~st_reg.ack_tog;
        end
    end

    // Kept out of the frame reset so toggles never flip at select rise.
    always_ff @(posedge i_sclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_ack_tog   = st_reg.ack_tog;
    assign o_ctrl_tog  = st_reg.ctrl_tog;
    assign o_ctrl_byte = st_reg.ctrl_byte;
    assign o_conv_word = st_reg.conv_word;

endmodule // adcsp_xfer

// ----------------------------------------------------------------
// Result shifter and strobe, falling serial clock
// ----------------------------------------------------------------
module adcsp_tx #(
    parameter int RES_W = `ADCSP_RES_W
) (
    // Link
    input  wire logic             i_sclk,
    input  wire logic             i_link_rst_b,
    input  wire logic             i_in_conv,
    input  wire logic             i_mode_int,
    input  wire logic [RES_W-1:0] i_word,
    // Outputs
    output logic                  o_dout,
    output logic                  o_dout_oe,
    output logic                  o_strobe,
    output logic                  o_done
);
    typedef struct packed {
        logic [4:0]       cnt;
        logic [RES_W-1:0] sh;
        logic             dout;
        logic             oe;
        logic             strobe;
    } adcsp_tx_st_t;

    adcsp_tx_st_t st_reg;
    adcsp_tx_st_t st_next;
    logic [4:0]   msb_c;
    logic [4:0]   lsb_c;

    always_comb begin
        st_next    = st_reg;
        st_next.oe = 1'b1;
        msb_c      = i_mode_int ? `ADCSP_CNT_MSB_INT : `ADCSP_CNT_MSB_EXT;
        lsb_c      = msb_c + 5'(RES_W - 1);
        if (st_reg.cnt == `ADCSP_CNT_END) begin
            if (!i_in_conv) begin
                st_next.cnt = 5'h00;
            end
        end else if (i_in_conv || st_reg.cnt != 5'h00) begin
            st_next.cnt = st_reg.cnt + 5'h01;
        end
        if (st_next.cnt == msb_c) begin
            {st_next.dout, st_next.sh} = {i_word, 1'b0};
        end else if (st_next.cnt > msb_c && st_next.cnt <= lsb_c) begin
            {st_next.dout, st_next.sh} = {st_reg.sh, 1'b0};
        end else begin
            st_next.dout = 1'b0;
        end
        st_next.strobe = !i_mode_int && (st_next.cnt == `ADCSP_CNT_STRB ||
                         st_next.cnt == `ADCSP_CNT_STRB + 5'h01);
    end

    // Falling edge only, so both outputs move there.
    always_ff @(negedge i_sclk or negedge i_link_rst_b) begin
        if (!i_link_rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_dout    = st_reg.dout;
    assign o_dout_oe = st_reg.oe;
    assign o_strobe  = st_reg.strobe;
    assign o_done    = (st_reg.cnt == `ADCSP_CNT_END);

    sequence s_strobe_two;
        st_reg.strobe [*2];
    endsequence

    property p_strobe_pulse;
        @(negedge i_sclk) disable iff (!i_link_rst_b)
        (!i_mode_int && st_reg.cnt == `ADCSP_CNT_STRB) |-> s_strobe_two ##1
            (!st_reg.strobe && st_reg.dout == i_word[RES_W-1]);
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse)
        else $error("Strobe was not high for two clocks before the MSB.");

    property p_shift;
        @(negedge i_sclk) disable iff (!i_link_rst_b)
        (st_reg.cnt >= msb_c && st_reg.cnt < lsb_c) |=> st_reg.dout == $past(st_reg.sh[RES_W-1]);
    endproperty
    a_shift: assert property (p_shift)
        else $error("Data out did not present the next result bit.");

    property p_conv_len;
        @(negedge i_sclk) disable iff (!i_link_rst_b)
        (!i_mode_int && st_reg.cnt == `ADCSP_CNT_STRB) |-> ##17 (st_reg.cnt == `ADCSP_CNT_END);
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("External conversion did not end on the eighteenth edge.");

endmodule // adcsp_tx

// ----------------------------------------------------------------
// Top: system clock side, result buffer and strobe driver
// ----------------------------------------------------------------
module adcsp_serial
    import adcsp_pkg::*;
#(
    parameter int          RES_W        = `ADCSP_RES_W,
    parameter int          BUF_DEPTH    = `ADCSP_BUF_DEPTH,
    parameter int unsigned INT_CONV_CYC = `ADCSP_INT_CONV_CYC
) (
    // System
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    // Serial link pins
    input  wire logic             i_sclk,
    input  wire logic             i_cs_n,
    input  wire logic             i_din,
    input  wire logic             i_shutdown_n_in,
    output logic                  o_dout,
    output logic                  o_dout_oe,
    output logic                  o_conversion_strobe_out,
    output logic                  o_conversion_strobe_oe,
    // Result stream in
    input  wire logic             i_result_valid,
    input  wire logic [RES_W-1:0] i_result_data,
    output logic                  o_result_ready,
    // Control out
    output logic [7:0]            o_ctrl_byte,
    output logic                  o_ctrl_stb,
    output logic                  o_shutdown_active
);
    localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
    localparam int CW = $clog2(BUF_DEPTH + 1);

    typedef struct packed {
        logic [BUF_DEPTH-1:0][RES_W-1:0] mem;
        logic [PW-1:0]                   wr_ptr;
        logic [PW-1:0]                   rd_ptr;
        logic [CW-1:0]                   count;
        logic                            ready;
        logic [RES_W-1:0]                hold;
        logic                            req_tog;
        logic                            busy;
        logic                            ack_s1;
        logic                            ack_s2;
        logic                            ack_seen;
        logic                            ctl_s1;
        logic                            ctl_s2;
        logic                            ctl_seen;
        logic [7:0]                      ctrl_byte;
        logic                            ctrl_stb;
        logic                            ext_s1;
        logic                            ext_s2;
        logic                            cs_s1;
        logic                            cs_s2;
        logic                            shutdown_n_in_s1;
        logic                            shutdown_n_in_s2;
        logic                            shut;
        logic                            mode_int;
        logic                            int_busy;
        logic [11:0]                     int_cnt;
        logic                            strobe;
        logic                            strobe_oe;
    } adcsp_top_st_t;

    adcsp_top_st_t   st_reg;
    adcsp_top_st_t   st_next;
    logic            link_rst_b;
    logic            byte_done;
    logic [7:0]      rx_byte;
    adcsp_rx_phase_t rx_phase;
    logic            tx_done;
    logic            tx_strobe;
    logic            ack_tog;
    logic            ctrl_tog;
    logic [7:0]      link_ctrl;
    logic [RES_W-1:0] conv_word;
    logic            push;
    logic            pop;
    logic            ctl_new;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        return (p == PW'(BUF_DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    // Pins reset the link directly; select pulses shorter than a system
    // clock are still honoured this way.
    assign link_rst_b = i_rst_b & ~i_cs_n & i_shutdown_n_in;

    adcsp_rx u_rx (
        .i_sclk       (i_sclk),
        .i_link_rst_b (link_rst_b),
        .i_din        (i_din),
        .i_conv_done  (tx_done),
        .o_byte_done  (byte_done),
        .o_byte       (rx_byte),
        .o_phase      (rx_phase)
    );

    adcsp_xfer #(.RES_W(RES_W)) u_xfer (
        .i_sclk      (i_sclk),
        .i_rst_b     (i_rst_b),
        .i_req_tog   (st_reg.req_tog),
        .i_hold_word (st_reg.hold),
        .o_ack_tog   (ack_tog),
        .i_byte_done (byte_done),
        .i_byte      (rx_byte),
        .o_ctrl_tog  (ctrl_tog),
        .o_ctrl_byte (link_ctrl),
        .o_conv_word (conv_word)
    );

    adcsp_tx #(.RES_W(RES_W)) u_tx (
        .i_sclk       (i_sclk),
        .i_link_rst_b (link_rst_b),
        .i_in_conv    (rx_phase == rx_conv),
        .i_mode_int   (link_ctrl[`ADCSP_MODE_HI:`ADCSP_MODE_LO] == `ADCSP_MODE_INT),
        .i_word       (conv_word),
        .o_dout       (o_dout),
        .o_dout_oe    (o_dout_oe),
        .o_strobe     (tx_strobe),
        .o_done       (tx_done)
    );

    always_comb begin
        st_next          = st_reg;
        st_next.ctrl_stb = 1'b0;
        st_next.ack_s1   = ack_tog;
        st_next.ack_s2   = st_reg.ack_s1;
        st_next.ctl_s1   = ctrl_tog;
        st_next.ctl_s2   = st_reg.ctl_s1;
        st_next.ext_s1   = tx_strobe;
        st_next.ext_s2   = st_reg.ext_s1;
        st_next.cs_s1    = i_cs_n;
        st_next.cs_s2    = st_reg.cs_s1;
        st_next.shutdown_n_in_s1  = i_shutdown_n_in;
        st_next.shutdown_n_in_s2  = st_reg.shutdown_n_in_s1;
        st_next.shut     = !st_reg.shutdown_n_in_s2;
        push    = i_result_valid && st_reg.ready;
        pop     = !st_reg.busy && st_reg.count != '0;
        ctl_new = st_reg.ctl_s2 != st_reg.ctl_seen;
        if (push) begin
            st_next.mem[st_reg.wr_ptr] = i_result_data;
            st_next.wr_ptr             = ptr_inc(st_reg.wr_ptr);
        end
        if (pop) begin
            st_next.hold    = st_reg.mem[st_reg.rd_ptr];
            st_next.rd_ptr  = ptr_inc(st_reg.rd_ptr);
            st_next.req_tog = ~st_reg.req_tog;
            st_next.busy    = 1'b1;
        end
        if (push && !pop) begin
            st_next.count = st_reg.count + CW'(1);
        end else if (pop && !push) begin
            st_next.count = st_reg.count - CW'(1);
        end
        if (st_reg.ack_s2 != st_reg.ack_seen) begin
            st_next.ack_seen = st_reg.ack_s2;
            st_next.busy     = 1'b0;
        end
        st_next.ready = st_reg.shutdown_n_in_s2 && (st_next.count < CW'(BUF_DEPTH));
        if (ctl_new) begin
            st_next.ctl_seen  = st_reg.ctl_s2;
            st_next.ctrl_byte = link_ctrl;
            st_next.ctrl_stb  = 1'b1;
            st_next.mode_int  = link_ctrl[`ADCSP_MODE_HI:`ADCSP_MODE_LO] == `ADCSP_MODE_INT;
            st_next.int_busy  = st_next.mode_int;
            st_next.int_cnt   = 12'(INT_CONV_CYC - 1);
        end else if (st_reg.int_busy) begin
            if (st_reg.int_cnt == 12'h000) begin
                st_next.int_busy = 1'b0;
            end else begin
                st_next.int_cnt = st_reg.int_cnt - 12'h001;
            end
        end
        if (!st_reg.shutdown_n_in_s2) begin
            st_next.int_busy = 1'b0;
        end
        if (st_next.mode_int) begin
            st_next.strobe    = !st_next.int_busy;
            st_next.strobe_oe = st_reg.shutdown_n_in_s2;
        end else begin
            st_next.strobe    = st_reg.ext_s2;
            st_next.strobe_oe = !st_reg.cs_s2 && st_reg.shutdown_n_in_s2;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_conversion_strobe_out = st_reg.strobe;
    assign o_conversion_strobe_oe  = st_reg.strobe_oe;
    assign o_result_ready          = st_reg.ready;
    assign o_ctrl_byte             = st_reg.ctrl_byte;
    assign o_ctrl_stb              = st_reg.ctrl_stb;
    assign o_shutdown_active       = st_reg.shut;

    property p_dout_released;
        @(posedge i_clk) disable iff (!i_rst_b)
        st_reg.cs_s2 |-> !o_dout_oe;
    endproperty
    a_dout_released: assert property (p_dout_released)
        else $error("Data out driven while select is high.");

    property p_strobe_released;
        @(posedge i_clk) disable iff (!i_rst_b)
        (!st_reg.mode_int && st_reg.cs_s2 && !ctl_new) |=> !st_reg.strobe_oe;
    endproperty
    a_strobe_released: assert property (p_strobe_released)
        else $error("External strobe driven while select is high.");

    property p_int_low;
        @(posedge i_clk) disable iff (!i_rst_b)
        (st_reg.mode_int && st_reg.int_busy && st_reg.int_cnt != 12'h000 &&
         st_reg.shutdown_n_in_s2 && !ctl_new) |=> (!st_reg.strobe && st_reg.int_busy);
    endproperty
    a_int_low: assert property (p_int_low)
        else $error("Internal strobe not low during conversion.");

    property p_int_done;
        @(posedge i_clk) disable iff (!i_rst_b)
        (st_reg.mode_int && st_reg.int_busy && st_reg.int_cnt == 12'h000 && !ctl_new)
            |=> (st_reg.strobe && !st_reg.int_busy);
    endproperty
    a_int_done: assert property (p_int_done)
        else $error("Internal strobe did not rise at conversion end.");

    property p_shutdown;
        @(posedge i_clk) disable iff (!i_rst_b)
        !st_reg.shutdown_n_in_s2 |=> (!o_result_ready && !st_reg.int_busy && !o_conversion_strobe_oe);
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("Block still active during shutdown.");

endmodule // adcsp_serial

// File: adcsp_cfg.svh
`ifndef ADCSP_CFG_SVH
`define ADCSP_CFG_SVH
// Summary of operation
// - Data out changes on falling clock, select low.
// - Data out released while select is high.
// - Data in sampled on rising clock edges.
// - Nothing shifted in while select is high.
// - Internal mode: strobe low during conversion.
// - External mode: strobe high two clocks before MSB.
// - External mode: strobe released while select high.
// - External mode: serial clock paces the conversion.
// - Shutdown input low stops the block.
// - First one after select falls starts byte.
// - External conversion ends on eighteenth falling edge.
// - Data out moves on falling edges; strobe pin moves on system clock.

// ----------------------------------------------------------------
// Widths and buffer
// ----------------------------------------------------------------
`define ADCSP_RES_W        14
`define ADCSP_BUF_DEPTH    2
`define ADCSP_CTRL_LAST    3'h7

// ----------------------------------------------------------------
// Control byte fields
// ----------------------------------------------------------------
`define ADCSP_MODE_HI      1
`define ADCSP_MODE_LO      0
`define ADCSP_MODE_INT     2'h2

// ----------------------------------------------------------------
// Falling-edge counts after the control byte
// ----------------------------------------------------------------
`define ADCSP_CNT_STRB     5'h01
`define ADCSP_CNT_MSB_EXT  5'h03
`define ADCSP_CNT_MSB_INT  5'h02
`define ADCSP_CNT_END      5'h12

// ----------------------------------------------------------------
// Internal conversion timing
// ----------------------------------------------------------------
`define ADCSP_CLK_MHZ      125
`define ADCSP_INT_CONV_NS  7500
`define ADCSP_INT_CONV_CYC ((`ADCSP_INT_CONV_NS * `ADCSP_CLK_MHZ + 999) / 1000)

`endif

// File: adcsp_pkg.sv
package adcsp_pkg;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        rx_hunt,
        rx_ctrl,
        rx_conv
    } adcsp_rx_phase_t;

endpackage

// File: adcsp_host.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Serial host model
// ----------------------------------------------------------------
module adcsp_host (
    // Link
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_din,
    // Device pins as seen on the wire
    input  wire logic i_dout,
    input  wire logic i_strobe,
    input  wire logic i_dout_oe
);
    logic [17:0] rx_bits = '0;
    logic [17:0] rx_strb = '0;
    logic        oe_seen = 1'b0;
    initial o_sclk = 1'b0;
    initial o_cs_n = 1'b1;
    initial o_din = 1'b0;

    // Clock rests low between frames; samples are taken just before each rise.
    task automatic clk_bit(input logic b);
        o_din = b;
        #80;
        rx_bits = {rx_bits[16:0], i_dout};
        rx_strb = {rx_strb[16:0], i_strobe};
        oe_seen = oe_seen | i_dout_oe;
        o_sclk = 1'b1;
        #80;
        o_sclk = 1'b0;
    endtask

    // Four leading zeros give the word handover its sclk edges.
    task automatic open_frame(input logic [7:0] ctrl);
        o_cs_n = 1'b0;
        oe_seen = 1'b0;
        #80;
        for (int i = 0; i < 12; i++) begin
            clk_bit(i < 4 ? 1'b0 : ctrl[11-i]);
        end
    endtask

    task automatic run_clocks(input int n, input logic b);
        for (int i = 0; i < n; i++) begin
            clk_bit(b);
        end
    endtask

    task automatic close_frame();
        #80;
        o_cs_n = 1'b1;
        #80;
    endtask
endmodule // adcsp_host

// File: tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) \
    begin \
        samples_checked++; \
        if ((g) !== (e)) begin \
            err_count++; \
            $display("wrong value %s exp %0h got %0h", nm, e, g); \
        end \
    end

// ----------------------------------------------------------------
// Testbench
// ----------------------------------------------------------------
module tb;
    logic        i_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic        i_shutdown_n_in_n = 1'b1;
    logic        i_valid = 1'b0;
    logic [13:0] i_data = '0;
    wire         sclk, cs_n, din, dout_w, strb_w;
    logic        o_dout, o_dout_oe, o_strb, o_strb_oe, o_ready;
    logic [7:0]  o_ctrl_byte;
    logic        o_ctrl_stb, o_shutdown_n_in_act;
    int          err_count = 0;
    int          samples_checked = 0;
    int          stb_cnt = 0;

    always #4 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        if (o_ctrl_stb === 1'b1) stb_cnt <= stb_cnt + 1;
    end
    assign dout_w = o_dout_oe ? o_dout : 1'bz;
    assign strb_w = o_strb_oe ? o_strb : 1'bz;

    adcsp_serial #(.INT_CONV_CYC(20)) u_adcsp_serial (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_din(din), .i_shutdown_n_in(i_shutdown_n_in_n), .o_dout(o_dout),
        .o_dout_oe(o_dout_oe), .o_conversion_strobe_out(o_strb),
        .o_conversion_strobe_oe(o_strb_oe), .i_result_valid(i_valid),
        .i_result_data(i_data), .o_result_ready(o_ready),
        .o_ctrl_byte(o_ctrl_byte), .o_ctrl_stb(o_ctrl_stb),
        .o_shutdown_active(o_shutdown_n_in_act));
    adcsp_host u_adcsp_host (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din),
        .i_dout(dout_w), .i_strobe(strb_w), .i_dout_oe(o_dout_oe));

    task automatic push(input logic [13:0] d);
        i_valid = 1'b1;
        i_data = d;
        for (int i = 0; i < 50 && o_ready !== 1'b1; i++) @(negedge i_clk);
        @(negedge i_clk);
    endtask

    // Two buffer entries plus the holding word: a fourth word must wait.
    task automatic t_fill();
        push(14'h2A5C);
        push(14'h1F03);
        push(14'h3FFE);
        i_valid = 1'b0;
        repeat (2) @(negedge i_clk);
        i_valid = 1'b1;
        i_data = 14'h0155;
        repeat (4) @(negedge i_clk);
        `CHK("ready full", 1'b0, o_ready)
        i_valid = 1'b0;
    endtask

    task automatic t_ext(input logic [7:0] c, input logic [13:0] w);
        int s0;
        s0 = stb_cnt;
        u_adcsp_host.open_frame(c);
        u_adcsp_host.run_clocks(18, 1'b0);
        u_adcsp_host.close_frame();
        @(negedge i_clk);
        `CHK("data", {w, 2'b00}, u_adcsp_host.rx_bits[15:0])
        `CHK("strobe", 18'h30000, u_adcsp_host.rx_strb)
        `CHK("ctrl", c, o_ctrl_byte)
        `CHK("stb", s0 + 1, stb_cnt)
        `CHK("dout oe", 1'b0, o_dout_oe)
        `CHK("strb oe", 1'b0, o_strb_oe)
    endtask

    task automatic t_int(input logic [13:0] w);
        int n;
        n = 0;
        push(w);
        i_valid = 1'b0;
        fork
            u_adcsp_host.open_frame(8'hFE);
            begin
                @(posedge o_ctrl_stb);
                @(negedge i_clk);
                while (o_strb === 1'b0 && n < 200) begin
                    n++;
                    @(negedge i_clk);
                end
            end
        join
        `CHK("conv len", 20, n)
        u_adcsp_host.run_clocks(18, 1'b0);
        u_adcsp_host.close_frame();
        @(negedge i_clk);
        `CHK("int data", w, u_adcsp_host.rx_bits[16:3])
    endtask

    task automatic t_stray();
        int s0;
        s0 = stb_cnt;
        u_adcsp_host.run_clocks(16, 1'b1);
        repeat (8) @(negedge i_clk);
        `CHK("stray stb", s0, stb_cnt)
        `CHK("stray oe", 1'b0, o_dout_oe)
    endtask

    task automatic t_shutdown_n_in();
        int s0;
        s0 = stb_cnt;
        i_shutdown_n_in_n = 1'b0;
        repeat (4) @(negedge i_clk);
        `CHK("shutdown_n_in act", 1'b1, o_shutdown_n_in_act)
        `CHK("shutdown_n_in rdy", 1'b0, o_ready)
        u_adcsp_host.open_frame(8'h8F);
        u_adcsp_host.run_clocks(18, 1'b0);
        u_adcsp_host.close_frame();
        @(negedge i_clk);
        `CHK("shutdown_n_in oe", 1'b0, u_adcsp_host.oe_seen)
        `CHK("shutdown_n_in stb", s0, stb_cnt)
        i_shutdown_n_in_n = 1'b1;
        repeat (4) @(negedge i_clk);
        `CHK("wake act", 1'b0, o_shutdown_n_in_act)
        `CHK("wake rdy", 1'b1, o_ready)
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(negedge i_clk);
        i_rst_b = 1'b1;
        repeat (4) @(negedge i_clk);
        `CHK("ready", 1'b1, o_ready)
        t_fill();
        t_ext(8'h8F, 14'h2A5C);
        t_stray();
        t_ext(8'hF1, 14'h1F03);
        t_ext(8'h8C, 14'h3FFE);
        `CHK("drained", 1'b1, o_ready)
        t_int(14'h0A81);
        t_shutdown_n_in();
        finish_test();
    end

    initial begin
        #500000;
        err_count++;
        finish_test();
    end
endmodule // tb
